// ===== hdl/host_port_descriptor_ring_dma.v
// host port engine: port commands, control block fetch, tx/rx descriptor rings
// assumes a memory slave that acks each request once, and that all
// inputs but the asynchronous rst_i are synchronous to clk_i
`include "host_port_regs.vh"

module host_port_descriptor_ring_dma #(
    parameter ADDR_W = 16,
    parameter RING_W = 8
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // port command register and control bits
    input wire cmd_write_i,
    input wire [3:0] cmd_code_i,
    input wire [15:0] cmd_arg_i,
    input wire reset_bit_i,
    input wire [3:0] flag_clear_i,
    // status flags and state
    output reg done_interrupt_flag_o,
    output reg command_error_interrupt_flag_o,
    output reg tx_ring_interrupt_flag_o,
    output reg rx_interrupt_flag_o,
    output reg [3:0] port_state_status_o,
    output reg [15:0] tx_frame_count_o,
    output reg [15:0] rx_frame_count_o,
    // host memory dma master
    output reg mem_req_o,
    output reg mem_we_o,
    output reg [ADDR_W-1:0] mem_addr_o,
    output reg [15:0] mem_wdata_o,
    input wire mem_ack_i,
    input wire [15:0] mem_rdata_i,
    // network transmit stream
    output reg tx_valid_o,
    output reg [15:0] tx_data_o,
    output reg tx_last_o,
    input wire tx_ready_i,
    // network receive stream
    input wire rx_valid_i,
    input wire [15:0] rx_data_i,
    input wire rx_last_i,
    output reg rx_ready_o
);

    reg [7:0] state_reg;
    reg cmd_pend_reg;
    reg [3:0] cmd_code_reg;
    reg [15:0] cmd_arg_reg;
    reg [ADDR_W-1:0] pcb_base_reg;
    reg [15:0] pcb_word [0:3];
    reg [1:0] word_reg;
    reg [ADDR_W-1:0] tx_base_reg;
    reg [ADDR_W-1:0] rx_base_reg;
    reg [RING_W-1:0] tx_count_reg;
    reg [RING_W-1:0] rx_count_reg;
    reg [RING_W-1:0] tx_ptr_reg;
    reg [RING_W-1:0] rx_ptr_reg;
    reg [15:0] desc_flags_reg;
    reg [15:0] desc_len_reg;
    reg [ADDR_W-1:0] desc_addr_reg;
    reg [15:0] cnt_reg;
    reg tx_scan_reg;
    reg sent_any_reg;
    reg rx_first_reg;
    reg rx_last_reg;
    reg rx_drop_reg;

    // an entry is three words: base + 3 * index
    wire [ADDR_W-1:0] tx_entry = tx_base_reg
        + {{(ADDR_W-RING_W-1){1'b0}}, tx_ptr_reg, 1'b0}
        + {{(ADDR_W-RING_W){1'b0}}, tx_ptr_reg};
    wire [ADDR_W-1:0] rx_entry = rx_base_reg
        + {{(ADDR_W-RING_W-1){1'b0}}, rx_ptr_reg, 1'b0}
        + {{(ADDR_W-RING_W){1'b0}}, rx_ptr_reg};
    wire [RING_W-1:0] ring_one = {{(RING_W-1){1'b0}}, 1'b1};
    wire [RING_W-1:0] tx_ptr_next = (tx_ptr_reg == tx_count_reg - ring_one)
        ? {RING_W{1'b0}} : tx_ptr_reg + ring_one;
    wire [RING_W-1:0] rx_ptr_next = (rx_ptr_reg == rx_count_reg - ring_one)
        ? {RING_W{1'b0}} : rx_ptr_reg + ring_one;
    wire [15:0] cnt_inc = cnt_reg + 16'h0001;
    wire running = (port_state_status_o == `FS_RUNNING);

    // shared by power-up reset and the soft reset bit
    task clear_all;
        begin
            state_reg <= `ST_IDLE;
            cmd_pend_reg <= 1'b0;
            cmd_code_reg <= `CMD_NOOP;
            cmd_arg_reg <= 16'h0000;
            pcb_base_reg <= {ADDR_W{1'b0}};
            word_reg <= 2'h0;
            tx_base_reg <= {ADDR_W{1'b0}};
            rx_base_reg <= {ADDR_W{1'b0}};
            tx_count_reg <= {RING_W{1'b0}};
            rx_count_reg <= {RING_W{1'b0}};
            tx_ptr_reg <= {RING_W{1'b0}};
            rx_ptr_reg <= {RING_W{1'b0}};
            desc_flags_reg <= 16'h0000;
            desc_len_reg <= 16'h0000;
            desc_addr_reg <= {ADDR_W{1'b0}};
            cnt_reg <= 16'h0000;
            tx_scan_reg <= 1'b0;
            sent_any_reg <= 1'b0;
            rx_first_reg <= 1'b0;
            rx_last_reg <= 1'b0;
            rx_drop_reg <= 1'b0;
            done_interrupt_flag_o <= 1'b0;
            command_error_interrupt_flag_o <= 1'b0;
            tx_ring_interrupt_flag_o <= 1'b0;
            rx_interrupt_flag_o <= 1'b0;
            port_state_status_o <= `FS_RESET;
            tx_frame_count_o <= 16'h0000;
            rx_frame_count_o <= 16'h0000;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= {ADDR_W{1'b0}};
            mem_wdata_o <= 16'h0000;
            tx_valid_o <= 1'b0;
            tx_data_o <= 16'h0000;
            tx_last_o <= 1'b0;
            rx_ready_o <= 1'b0;
        end
    endtask

    integer i;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clear_all;
            for (i = 0; i < 4; i = i + 1)
                pcb_word[i] <= 16'h0000;
        end else if (reset_bit_i) begin
            clear_all;
        end else begin
            // reset state lasts one cycle, then ready
            if (port_state_status_o == `FS_RESET)
                port_state_status_o <= `FS_READY;
            // clears first; any set further down wins
            if (flag_clear_i[`CLR_DONE])
                done_interrupt_flag_o <= 1'b0;
            if (flag_clear_i[`CLR_ERR])
                command_error_interrupt_flag_o <= 1'b0;
            if (flag_clear_i[`CLR_TX])
                tx_ring_interrupt_flag_o <= 1'b0;
            if (flag_clear_i[`CLR_RX])
                rx_interrupt_flag_o <= 1'b0;
            // latched in any state, run when idle
            if (cmd_write_i) begin
                if (cmd_pend_reg)
                    command_error_interrupt_flag_o <= 1'b1;
                else begin
                    cmd_pend_reg <= 1'b1;
                    cmd_code_reg <= cmd_code_i;
                    cmd_arg_reg <= cmd_arg_i;
                end
            end
            case (state_reg)
            `ST_IDLE: begin
                if (cmd_pend_reg) begin
                    cmd_pend_reg <= 1'b0;
                    case (cmd_code_reg)
                    `CMD_NOOP: begin
                        done_interrupt_flag_o <= 1'b1;
                    end
                    `CMD_FETCH_BASE: begin
                        pcb_base_reg <= cmd_arg_reg[ADDR_W-1:0];
                        done_interrupt_flag_o <= 1'b1;
                    end
                    `CMD_FETCH_CMD: begin
                        word_reg <= 2'h0;
                        state_reg <= `ST_PCB_RD;
                    end
                    `CMD_XMIT_POLL: begin
                        if (running) begin
                            tx_scan_reg <= 1'b1;
                            sent_any_reg <= 1'b0;
                            done_interrupt_flag_o <= 1'b1;
                        end else
                            command_error_interrupt_flag_o <= 1'b1;
                    end
                    `CMD_START: begin
                        port_state_status_o <= `FS_RUNNING;
                        done_interrupt_flag_o <= 1'b1;
                    end
                    `CMD_STOP: begin
                        port_state_status_o <= `FS_READY;
                        tx_scan_reg <= 1'b0;
                        done_interrupt_flag_o <= 1'b1;
                    end
                    default: begin
                        command_error_interrupt_flag_o <= 1'b1;
                    end
                    endcase
                end else if (running && rx_valid_i && rx_count_reg != 0) begin
                    // rx before tx: received words cannot be held off for long
                    word_reg <= 2'h0;
                    rx_first_reg <= 1'b1;
                    rx_last_reg <= 1'b0;
                    state_reg <= `ST_RX_DESC;
                end else if (running && tx_scan_reg && tx_count_reg != 0) begin
                    word_reg <= 2'h0;
                    state_reg <= `ST_TX_DESC;
                end
            end
            `ST_PCB_RD: begin
                if (!mem_req_o) begin
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b0;
                    mem_addr_o <= pcb_base_reg + {{(ADDR_W-2){1'b0}}, word_reg};
                end else if (mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    pcb_word[word_reg] <= mem_rdata_i;
                    word_reg <= word_reg + 2'h1;
                    if (word_reg == `PCB_LASTW) begin
                        state_reg <= `ST_IDLE;
                        case (pcb_word[0])
                        `FN_NOP: done_interrupt_flag_o <= 1'b1;
                        `FN_TX_RING: begin
                            tx_base_reg <= pcb_word[1][ADDR_W-1:0];
                            tx_count_reg <= pcb_word[2][RING_W-1:0];
                            tx_ptr_reg <= {RING_W{1'b0}};
                            done_interrupt_flag_o <= 1'b1;
                        end
                        `FN_RX_RING: begin
                            rx_base_reg <= pcb_word[1][ADDR_W-1:0];
                            rx_count_reg <= pcb_word[2][RING_W-1:0];
                            rx_ptr_reg <= {RING_W{1'b0}};
                            done_interrupt_flag_o <= 1'b1;
                        end
                        default: command_error_interrupt_flag_o <= 1'b1;
                        endcase
                    end
                end
            end
            `ST_TX_DESC: begin
                if (!mem_req_o) begin
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b0;
                    mem_addr_o <= tx_entry + {{(ADDR_W-2){1'b0}}, word_reg};
                end else if (mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    word_reg <= word_reg + 2'h1;
                    if (word_reg == `DESC_W_FLAGS) begin
                        desc_flags_reg <= mem_rdata_i;
                        if (!mem_rdata_i[`DESC_OWN]) begin
                            // unowned entry ends the scan
                            tx_scan_reg <= 1'b0;
                            if (sent_any_reg)
                                tx_ring_interrupt_flag_o <= 1'b1;
                            state_reg <= `ST_IDLE;
                        end
                    end else if (word_reg == `DESC_W_LEN)
                        desc_len_reg <= mem_rdata_i;
                    else begin
                        desc_addr_reg <= mem_rdata_i[ADDR_W-1:0];
                        cnt_reg <= 16'h0000;
                        state_reg <= (desc_len_reg == 0) ? `ST_TX_STAT : `ST_TX_DATA;
                    end
                end
            end
            `ST_TX_DATA: begin
                if (tx_valid_o) begin
                    if (tx_ready_i) begin
                        tx_valid_o <= 1'b0;
                        tx_last_o <= 1'b0;
                        cnt_reg <= cnt_inc;
                        if (cnt_inc == desc_len_reg)
                            state_reg <= `ST_TX_STAT;
                    end
                end else if (!mem_req_o) begin
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b0;
                    mem_addr_o <= desc_addr_reg + cnt_reg[ADDR_W-1:0];
                end else if (mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    tx_valid_o <= 1'b1;
                    tx_data_o <= mem_rdata_i;
                    // eof entry ends the frame; else the next chains on
                    tx_last_o <= desc_flags_reg[`DESC_EOF]
                        && (cnt_inc == desc_len_reg);
                end
            end
            `ST_TX_STAT: begin
                if (!mem_req_o) begin
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b1;
                    mem_addr_o <= tx_entry;
                    mem_wdata_o <= desc_flags_reg & ~(16'h0001 << `DESC_OWN);
                end else if (mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    mem_we_o <= 1'b0;
                    tx_ptr_reg <= tx_ptr_next;
                    word_reg <= 2'h0;
                    if (desc_flags_reg[`DESC_EOF]) begin
                        sent_any_reg <= 1'b1;
                        tx_frame_count_o <= tx_frame_count_o + 16'h0001;
                    end
                    state_reg <= `ST_TX_DESC;
                end
            end
            `ST_RX_DESC: begin
                if (!mem_req_o) begin
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b0;
                    mem_addr_o <= rx_entry + {{(ADDR_W-2){1'b0}}, word_reg};
                end else if (mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    word_reg <= word_reg + 2'h1;
                    if (word_reg == `DESC_W_FLAGS) begin
                        desc_flags_reg <= mem_rdata_i;
                        if (!mem_rdata_i[`DESC_OWN]) begin
                            // no buffer: the rest of the frame is discarded
                            rx_drop_reg <= 1'b1;
                            rx_ready_o <= 1'b1;
                            state_reg <= `ST_RX_DATA;
                        end
                    end else if (word_reg == `DESC_W_LEN)
                        desc_len_reg <= mem_rdata_i;
                    else begin
                        desc_addr_reg <= mem_rdata_i[ADDR_W-1:0];
                        cnt_reg <= 16'h0000;
                        rx_ready_o <= (desc_len_reg != 0);
                        state_reg <= (desc_len_reg == 0) ? `ST_RX_STAT : `ST_RX_DATA;
                    end
                end
            end
            `ST_RX_DATA: begin
                if (rx_drop_reg) begin
                    if (rx_valid_i && rx_last_i) begin
                        rx_drop_reg <= 1'b0;
                        rx_ready_o <= 1'b0;
                        state_reg <= `ST_IDLE;
                    end
                end else if (mem_req_o) begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o <= 1'b0;
                        cnt_reg <= cnt_inc;
                        // buffer full mid-frame: next owned one
                        if (rx_last_reg || cnt_inc == desc_len_reg)
                            state_reg <= `ST_RX_STAT;
                        else
                            rx_ready_o <= 1'b1;
                    end
                end else if (rx_ready_o && rx_valid_i) begin
                    rx_ready_o <= 1'b0;
                    rx_last_reg <= rx_last_i;
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b1;
                    mem_addr_o <= desc_addr_reg + cnt_reg[ADDR_W-1:0];
                    mem_wdata_o <= rx_data_i;
                end
            end
            `ST_RX_STAT: begin
                if (!mem_req_o) begin
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b1;
                    mem_addr_o <= rx_entry;
                    mem_wdata_o <= (desc_flags_reg
                        & ~((16'h0001 << `DESC_OWN) | (16'h0001 << `DESC_SOF)
                        | (16'h0001 << `DESC_EOF)))
                        | ({15'h0000, rx_first_reg} << `DESC_SOF)
                        | ({15'h0000, rx_last_reg} << `DESC_EOF);
                end else if (mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    mem_we_o <= 1'b0;
                    rx_ptr_reg <= rx_ptr_next;
                    rx_first_reg <= 1'b0;
                    word_reg <= 2'h0;
                    if (rx_last_reg) begin
                        rx_interrupt_flag_o <= 1'b1;
                        rx_frame_count_o <= rx_frame_count_o + 16'h0001;
                        state_reg <= `ST_IDLE;
                    end else
                        state_reg <= `ST_RX_DESC;
                end
            end
            default: state_reg <= `ST_IDLE;
            endcase
        end
    end

endmodule

// ===== hdl/host_port_regs.vh
// constants for the host port ring dma engine
// assumes a 16-bit host memory word and one clock domain
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH

// port command codes, bits 3:0
`define CMD_NOOP 4'h0
`define CMD_FETCH_BASE 4'h1
`define CMD_FETCH_CMD 4'h2
`define CMD_XMIT_POLL 4'h3
`define CMD_START 4'h4
`define CMD_STOP 4'h5

// functional state codes, bits 3:0
`define FS_RESET 4'h0
`define FS_READY 4'h1
`define FS_LOAD 4'h2
`define FS_RUNNING 4'h3

// one-hot engine states
`define ST_IDLE 8'h01
`define ST_PCB_RD 8'h02
`define ST_TX_DESC 8'h04
`define ST_TX_DATA 8'h08
`define ST_TX_STAT 8'h10
`define ST_RX_DESC 8'h20
`define ST_RX_DATA 8'h40
`define ST_RX_STAT 8'h80

// flag clear mask bits
`define CLR_DONE 0
`define CLR_ERR 1
`define CLR_TX 2
`define CLR_RX 3

// entry word 0 bits; word 1 length, word 2 buffer
`define DESC_OWN 15
`define DESC_SOF 1
`define DESC_EOF 0
`define DESC_W_FLAGS 2'h0
`define DESC_W_LEN 2'h1
`define DESC_W_ADDR 2'h2

// control block: word 0 function, 1..3 parameters
`define PCB_LASTW 2'h3
`define FN_NOP 16'h0000
`define FN_TX_RING 16'h0001
`define FN_RX_RING 16'h0002

`endif

// ===== bench/host_mem_model.sv
// word memory standing in for host memory behind the dma engine
// assumes one request at a time, held until acked
module host_mem_model (
    // clock and reset
    input clk_i,
    input rst_i,
    // request side
    input req_i,
    input we_i,
    input [15:0] addr_i,
    input [15:0] wdata_i,
    input slow_i,
    // answer side
    output logic ack_o,
    output logic [15:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:255];
    // read data toggles outside an ack so stale words never look valid
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            rdata_o <= 16'h5a5a;
        end else if (req_i && !ack_o && (!slow_i || $urandom % 4 == 0)) begin
            ack_o <= 1'b1;
            rdata_o <= mem[addr_i[7:0]];
            if (we_i)
                mem[addr_i[7:0]] <= wdata_i;
        end else begin
            ack_o <= 1'b0;
            rdata_o <= ~rdata_o;
        end
    end
endmodule

// ===== bench/host_port_descriptor_ring_dma_properties.sv
// port-level checks for the ring dma engine, bound to its top module
// assumes one clock domain with asynchronous active-high reset
`include "host_port_regs.vh"
module host_port_descriptor_ring_dma_properties #(
    parameter ADDR_W = 16
) (
    // clock, reset and commands
    input clk_i,
    input rst_i,
    input cmd_write_i,
    input [3:0] cmd_code_i,
    input reset_bit_i,
    // flags and state
    input done_interrupt_flag_o,
    input tx_ring_interrupt_flag_o,
    input rx_interrupt_flag_o,
    input [3:0] port_state_status_o,
    // memory and streams
    input mem_req_o,
    input [ADDR_W-1:0] mem_addr_o,
    input mem_ack_i,
    input tx_valid_o,
    input [15:0] tx_data_o,
    input tx_last_o,
    input tx_ready_i,
    input rx_valid_i,
    input rx_last_i,
    input rx_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // frame ends since poll or last rx flag
    logic tx_end, rx_end;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_end <= 1'b0;
            rx_end <= 1'b0;
        end else begin
            if (cmd_write_i && cmd_code_i == `CMD_XMIT_POLL)
                tx_end <= 1'b0;
            else if (tx_valid_o && tx_ready_i && tx_last_o)
                tx_end <= 1'b1;
            if ($rose(rx_interrupt_flag_o))
                rx_end <= 1'b0;
            else if (rx_valid_i && rx_ready_o && rx_last_i)
                rx_end <= 1'b1;
        end
    end
    property p_state_code;
        port_state_status_o inside {`FS_RESET, `FS_READY, `FS_RUNNING};
    endproperty
    a_state_code: assert property (p_state_code) else $error("bad state code");
    property p_run_done;
        $changed(port_state_status_o) && port_state_status_o == `FS_RUNNING |-> done_interrupt_flag_o;
    endproperty
    a_run_done: assert property (p_run_done) else $error("running without done");
    property p_idle_quiet;
        port_state_status_o != `FS_RUNNING |-> !tx_valid_o && !rx_ready_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("frames while not running");
    property p_mem_hold;
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("request changed before ack");
    property p_mem_gap; mem_ack_i |=> !mem_req_o; endproperty
    a_mem_gap: assert property (p_mem_gap) else $error("no idle cycle after ack");
    property p_tx_hold;
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_data_o, tx_last_o});
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx word changed while stalled");
    property p_tx_flag; $rose(tx_ring_interrupt_flag_o) |-> tx_end; endproperty
    a_tx_flag: assert property (p_tx_flag) else $error("tx flag without frame");
    property p_rx_flag; $rose(rx_interrupt_flag_o) |-> rx_end; endproperty
    a_rx_flag: assert property (p_rx_flag) else $error("rx flag without frame");
    property p_soft_reset;
        reset_bit_i |=> port_state_status_o == `FS_RESET && !done_interrupt_flag_o;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("reset bit did not clear");
    c_tx_frame: cover property ($rose(tx_ring_interrupt_flag_o));
    c_rx_frame: cover property ($rose(rx_interrupt_flag_o));
    c_tx_stall: cover property (tx_valid_o && !tx_ready_i ##1 tx_ready_i);
endmodule
bind host_port_descriptor_ring_dma host_port_descriptor_ring_dma_properties #(.ADDR_W(ADDR_W))
    props_inst (.*);

// ===== bench/tb_host_port_descriptor_ring_dma.sv
// bench for the ring dma engine: commands, control block fetch, tx and rx rings
// assumes host_mem_model answers every memory request of the engine
`include "host_port_regs.vh"
module tb_host_port_descriptor_ring_dma;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, cmd_write_i = 0, reset_bit_i = 0, slow = 0, tx_ready_i = 0;
    logic rx_valid_i = 0, rx_last_i = 0, mem_req_o, mem_we_o, mem_ack_i, tx_valid_o, tx_last_o;
    logic done_interrupt_flag_o, command_error_interrupt_flag_o, tx_ring_interrupt_flag_o;
    logic rx_interrupt_flag_o, rx_ready_o;
    logic [3:0] cmd_code_i = 0, flag_clear_i = 0, port_state_status_o, flags;
    logic [15:0] cmd_arg_i = 0, rx_data_i = 0, tx_frame_count_o, rx_frame_count_o, mem_addr_o;
    logic [15:0] mem_wdata_o, mem_rdata_i, tx_data_o, d[0:3];
    logic [16:0] txq[$];
    int mismatches = 0, num_checks = 0, n, k, w, nf = 0;
    assign flags = {rx_interrupt_flag_o, tx_ring_interrupt_flag_o,
        command_error_interrupt_flag_o, done_interrupt_flag_o};
    host_port_descriptor_ring_dma host_port_descriptor_ring_dma_inst (.*);
    host_mem_model host_mem_model_inst (.clk_i, .rst_i, .req_i(mem_req_o), .we_i(mem_we_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .slow_i(slow), .ack_o(mem_ack_i),
        .rdata_o(mem_rdata_i));
    initial forever #50 clk_i = ~clk_i;
    initial begin
        #3000000;
        mismatches++;
        tally_and_finish();
    end
    // random sink stalls keep the tx hold rule busy
    always @(posedge clk_i) begin
        tx_ready_i <= 1'($urandom % 2);
        if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
            txq.push_back({tx_last_o, tx_data_o});
    end
    function automatic logic [15:0] mw(input int a);
        return host_mem_model_inst.mem[a];
    endfunction
    function automatic logic [15:0] exp_last(input int i, nw, input logic e);
        return 16'(i == nw || (e && i == nw - 1));
    endfunction
    function automatic logic [15:0] rx_stat(input logic sof, eof);
        return {14'h0000, sof, eof};
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // flags word written last so the engine never sees a half-built entry
    task automatic desc(input int a, input logic [15:0] f, l, b);
        host_mem_model_inst.mem[a + 1] = l;
        host_mem_model_inst.mem[a + 2] = b;
        host_mem_model_inst.mem[a] = f;
    endtask
    task automatic wait_flag(input logic [3:0] m);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while ((|(flags & m)) !== 1'b1 && n < 3000);
    endtask
    task automatic cmd(input logic [3:0] code, input logic err, input int lat,
        input logic [15:0] arg = 16'h0000);
        @(posedge clk_i);
        flag_clear_i <= 4'hf;
        @(posedge clk_i);
        flag_clear_i <= 4'h0;
        cmd_write_i <= 1'b1;
        cmd_code_i <= code;
        cmd_arg_i <= arg;
        @(posedge clk_i);
        cmd_write_i <= 1'b0;
        wait_flag(4'h3);
        chk("cmd flags", {14'h0000, err, ~err}, {14'h0000, flags[1:0]});
        if (lat > 0)
            chk("cmd latency", 16'(lat), 16'(n));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        void'($urandom(1));
        repeat (3) @(posedge clk_i);
        chk("state", `FS_RESET, port_state_status_o);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("state", `FS_READY, port_state_status_o);
        cmd(`CMD_NOOP, 1'b0, 1);
        cmd(4'hf, 1'b1, 1);
        cmd(`CMD_XMIT_POLL, 1'b1, 1);
        cmd(`CMD_FETCH_BASE, 1'b0, 1, 16'h0040);
        desc('h40, 16'h00ff, 16'h0000, 16'h0000);
        cmd(`CMD_FETCH_CMD, 1'b1, 0);
        for (k = 0; k < 2; k++) begin
            desc('h40, k ? `FN_RX_RING : `FN_TX_RING, k ? 16'h0020 : 16'h0010, 16'h0002);
            cmd(`CMD_FETCH_CMD, 1'b0, 0);
        end
        cmd(`CMD_START, 1'b0, 1);
        chk("state", `FS_RUNNING, port_state_status_o);
        cmd(`CMD_STOP, 1'b0, 1);
        chk("state", `FS_READY, port_state_status_o);
        @(posedge clk_i);
        rx_valid_i <= 1'b1;
        repeat (20) begin
            @(posedge clk_i);
            chk("rx ready", 16'h0000, 16'(rx_ready_o));
        end
        rx_valid_i <= 1'b0;
        cmd(`CMD_START, 1'b0, 1);
        for (int r = 0; r < 4; r++) begin
            slow <= r[0];
            w = 1 + $urandom % 3;
            for (k = 0; k <= w; k++) begin
                d[k] = 16'($urandom);
                host_mem_model_inst.mem[k < w ? 'h80 + k : 'h90] = d[k];
            end
            desc('h13, 16'h8001, 16'h0001, 16'h0090);
            desc('h10, {1'b1, 14'h0000, r[1]}, 16'(w), 16'h0080);
            txq.delete();
            cmd(`CMD_XMIT_POLL, 1'b0, 1);
            wait_flag(4'h4);
            nf += 1 + r[1];
            chk("tx words", 16'(w + 1), 16'(txq.size()));
            for (k = 0; k <= w && k < txq.size(); k++) begin
                chk("tx data", d[k], txq[k][15:0]);
                chk("tx last", exp_last(k, w, r[1]), 16'(txq[k][16]));
            end
            chk("tx own", 16'h0000, mw('h10) & 16'h8000);
            chk("tx own", 16'h0000, mw('h13) & 16'h8000);
            chk("tx count", 16'(nf), tx_frame_count_o);
        end
        for (int r = 0; r < 2; r++) begin
            w = r ? 1 : 3;
            desc('h20, 16'h8000, 16'h0002, 16'h00a0);
            desc('h23, 16'h8000, 16'h0002, 16'h00b0);
            cmd(`CMD_NOOP, 1'b0, 0);
            @(posedge clk_i);
            for (k = 0; k < w; k++) begin
                d[k] = 16'($urandom);
                rx_valid_i <= 1'b1;
                rx_data_i <= d[k];
                rx_last_i <= (k == w - 1);
                n = 0;
                do begin
                    @(posedge clk_i);
                    n++;
                end while (rx_ready_o !== 1'b1 && n < 3000);
            end
            rx_valid_i <= 1'b0;
            rx_last_i <= 1'b0;
            rx_data_i <= ~rx_data_i;
            wait_flag(4'h8);
            for (k = 0; k < w; k++)
                chk("rx data", d[k], mw(k < 2 ? 'ha0 + k : 'hb0 + k - 2));
            chk("rx stat", rx_stat(1'b1, 1'(r)), mw('h20) & 16'h8003);
            if (r == 0)
                chk("rx stat", rx_stat(1'b0, 1'b1), mw('h23) & 16'h8003);
            chk("rx count", 16'(r + 1), rx_frame_count_o);
        end
        @(posedge clk_i);
        reset_bit_i <= 1'b1;
        @(posedge clk_i);
        reset_bit_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        chk("state", `FS_READY, port_state_status_o);
        chk("tx count", 16'h0000, tx_frame_count_o);
        chk("rx flag", 16'h0000, 16'(rx_interrupt_flag_o));
        cmd(`CMD_NOOP, 1'b0, 1);
        tally_and_finish();
    end
endmodule
